// >>> verilog/smart_switch_indicator_logic.sv
// Output and indicator logic of a multi-channel smart switch
`timescale 1ns/1ps
// Notes on behaviour
// - Outputs follow present inputs, present states and the prior supply and load states.
// - An unpowered switch supply forces the fault state to detected.
// - The fault state clears by itself once all fault conditions are gone.
// - Fault, lamp and open-load pins are active-low open-drain; fault is undefined unpowered.
// - Between the thresholds the switch supply is warning (powered without the warning variant); below the low one unpowered.
// - The supply warning indicator follows only a supply state that has held long enough.
// - An over-temperature fault on a channel that is on does not switch it off at once.
// - An over-temperature fault on a channel that is off keeps it from turning on.
// - An over-voltage fault leaves channel switching untouched.
// - The open-load indicator is asserted when any channel load is not detected.
// - The open-load indicator follows only a load state that has held long enough.
// - Below its threshold the logic supply counts as unpowered, above it as powered.
module smart_switch_indicator_logic #(
   parameter int CHANNELS = 4,
   parameter int SETTLE_CYCLES = ssw_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Host channel controls
   input wire logic [CHANNELS-1:0] channel_control_input,
   input wire logic output_enable,
   // Supply monitor comparators
   input wire logic logic_supply_above_uv,
   input wire logic switch_supply_above_low,
   input wire logic switch_supply_above_high,
   // Fault sensors
   input wire logic [CHANNELS-1:0] over_current,
   input wire logic [CHANNELS-1:0] over_temp,
   input wire logic [CHANNELS-1:0] over_voltage,
   input wire logic [CHANNELS-1:0] load_present,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Switch outputs
   output logic [CHANNELS-1:0] switch_output,
   // Open-drain indicators: low level is driven while enable is high
   output logic fault_indicator_n_out,
   output logic fault_indicator_n_oe,
   output logic [CHANNELS-1:0] channel_status_lamp_n_out,
   output logic [CHANNELS-1:0] channel_status_lamp_n_oe,
   output logic open_load_indicator_n_out,
   output logic open_load_indicator_n_oe,
   output logic switch_supply_warning_n_out,
   output logic switch_supply_warning_n_oe,
   // Interrupt
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Supply classification
   ////////////////////////////////////////////////////////////////////////////
   ssw_pkg::supply_e sw_state;
   logic logic_supply_ok;
   logic warn_variant;
   logic [31:0] ctrl_r;
   logic warn_raw;
   logic warn_settled;
   logic open_raw;
   logic open_settled;
   logic fault_now;
   logic [CHANNELS-1:0] gate_on;
   logic [CHANNELS-1:0] sensed_fault;
   logic [ssw_pkg::IRQ_W-1:0] int_stat_r;
   logic [ssw_pkg::IRQ_W-1:0] int_stat_nxt;
   logic [ssw_pkg::IRQ_W-1:0] int_en_r;
   logic [ssw_pkg::IRQ_W-1:0] events;
   logic fault_q_r;
   logic warn_q_r;
   logic open_q_r;
   logic temp_seen;
   logic volt_seen;

   // Variant select: warning band pin, or a two-level supply; the open-load pin is driven in both
   assign warn_variant = ctrl_r[ssw_pkg::CTRL_WARN_VARIANT];
   assign logic_supply_ok = logic_supply_above_uv;

   always_comb
   begin
      if (switch_supply_above_high)
         sw_state = ssw_pkg::SUP_P;
      else if (warn_variant && switch_supply_above_low)
         sw_state = ssw_pkg::SUP_W;
      else if (!warn_variant && switch_supply_above_low)
         sw_state = ssw_pkg::SUP_P;
      else
         sw_state = ssw_pkg::SUP_NP;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault state
   ////////////////////////////////////////////////////////////////////////////
   // Over-voltage is reported elsewhere and never gates switching
   // over-voltage ignored
   assign sensed_fault = over_current;

   // Purely combinational fault: no latch, so it clears without host action
   // supply loss forces fault
   assign fault_now = (sw_state == ssw_pkg::SUP_NP) || (|sensed_fault);

   // Constraint faults never raise the fault state, but software can still see them
   // reported, not in fault state
   assign temp_seen = |over_temp;
   assign volt_seen = |over_voltage;

   ////////////////////////////////////////////////////////////////////////////
   // Channel gating
   ////////////////////////////////////////////////////////////////////////////
   // One gate per channel, each holding its own temperature state
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : gen_ch
         channel_gate u_gate (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .request(channel_control_input[g] & output_enable),
            .run_ok(logic_supply_ok & ~fault_now),
            .temp_fault(over_temp[g]),
            .switch_on(gate_on[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Settled indicator sources
   ////////////////////////////////////////////////////////////////////////////
   // Warning shows for warn state, and for a drop to off straight from warning
   // previous supply state
   assign warn_raw = (sw_state == ssw_pkg::SUP_W) ||
                     (sw_state == ssw_pkg::SUP_NP && warn_settled);
   // previous load state on supply loss
   assign open_raw = (sw_state == ssw_pkg::SUP_NP) ? open_settled : ~(&load_present);

   // Both paths share one settle time, so supply and load are measured alike
   // supply settle
   settle_filter #(
      .CYCLES(SETTLE_CYCLES),
      .CNT_W(ssw_pkg::CNT_W)
   ) u_warn_filter (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .raw(warn_raw),
      .settled(warn_settled)
   );

   settle_filter #(
      .CYCLES(SETTLE_CYCLES),
      .CNT_W(ssw_pkg::CNT_W)
   ) u_open_filter (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .raw(open_raw),
      .settled(open_settled)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers
   ////////////////////////////////////////////////////////////////////////////
   // Switch and lamp share one source, so a lamp never claims a dead output
   // shutdown in fault
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         switch_output <= '0;
         channel_status_lamp_n_oe <= '0;
      end
      else
      begin
         switch_output <= gate_on;
         channel_status_lamp_n_oe <= gate_on;
      end
   end

   // Open-drain pins only ever pull low; enable high means asserted
   // active-low open-drain
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         fault_indicator_n_out <= 1'b0;
         channel_status_lamp_n_out <= '0;
         open_load_indicator_n_out <= 1'b0;
         switch_supply_warning_n_out <= 1'b0;
      end
      else
      begin
         fault_indicator_n_out <= 1'b0;
         channel_status_lamp_n_out <= '0;
         open_load_indicator_n_out <= 1'b0;
         switch_supply_warning_n_out <= 1'b0;
      end
   end

   // Undetermined while the logic side is unpowered: released here
   // fault pin asserted
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         fault_indicator_n_oe <= 1'b0;
      else
         fault_indicator_n_oe <= logic_supply_ok & fault_now;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         open_load_indicator_n_oe <= 1'b0;
      else
         open_load_indicator_n_oe <= logic_supply_ok & open_settled;
   end

   // Only the warning variant owns this pin; the other keeps it released
   // warning pin
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         switch_supply_warning_n_oe <= 1'b0;
      else
         switch_supply_warning_n_oe <= logic_supply_ok & warn_variant & warn_settled;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts on indicator rising edges
   ////////////////////////////////////////////////////////////////////////////
   // Previous levels reset to idle, so no false edge follows reset
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         fault_q_r <= 1'b0;
      else
         fault_q_r <= fault_now;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         warn_q_r <= 1'b0;
      else
         warn_q_r <= warn_settled;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         open_q_r <= 1'b0;
      else
         open_q_r <= open_settled;
   end

   // Rising edges of each indicator source
   assign events[ssw_pkg::IRQ_FAULT] = fault_now & ~fault_q_r;
   assign events[ssw_pkg::IRQ_WARN] = warn_settled & ~warn_q_r;
   assign events[ssw_pkg::IRQ_OPEN] = open_settled & ~open_q_r;

   // Set beats clear so no event is lost
   always_comb
   begin
      int_stat_nxt = int_stat_r;
      if (reg_wr && reg_addr == ssw_pkg::ADDR_INT_CLR)
         int_stat_nxt = int_stat_nxt & ~reg_wdata[ssw_pkg::IRQ_W-1:0];
      int_stat_nxt = int_stat_nxt | events;
   end

   // Sticky status bits
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         int_stat_r <= '0;
      else
         int_stat_r <= int_stat_nxt;
   end

   // Level interrupt from the next status, so it rises with its bit
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         irq <= 1'b0;
      else
         irq <= |(int_stat_nxt & int_en_r);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   ////////////////////////////////////////////////////////////////////////////
   // Control register: only the variant bit is kept, the rest reads as zero
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         ctrl_r <= ssw_pkg::RESET_CTRL;
      else if (reg_wr && reg_addr == ssw_pkg::ADDR_CTRL)
         ctrl_r <= {31'h0, reg_wdata[ssw_pkg::CTRL_WARN_VARIANT]};
   end

   // Enable mask: a set bit lets its status bit drive the interrupt
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         int_en_r <= '0;
      else if (reg_wr && reg_addr == ssw_pkg::ADDR_INT_EN)
         int_en_r <= reg_wdata[ssw_pkg::IRQ_W-1:0];
   end

   // Read data valid the cycle after the strobe; unmapped reads as zero
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            ssw_pkg::ADDR_CTRL: reg_rdata <= ctrl_r;
            ssw_pkg::ADDR_STAT: reg_rdata <= {24'h0, volt_seen, temp_seen,
                                              open_settled, warn_settled,
                                              fault_now, logic_supply_ok, sw_state};
            ssw_pkg::ADDR_INT_STAT: reg_rdata <= {29'h0, int_stat_r};
            ssw_pkg::ADDR_INT_EN: reg_rdata <= {29'h0, int_en_r};
            default: reg_rdata <= '0;
         endcase
      end
      else
         reg_rdata <= '0;
   end
endmodule

// >>> verilog/ssw_pkg.sv
// Shared constants for the smart switch indicator logic
package ssw_pkg;
   // Supply state encoding of the monitor inputs
   typedef enum logic [1:0] {SUP_NP, SUP_W, SUP_P} supply_e;
   // Settle time before an indicator may follow a new state
   localparam int SETTLE_US = 10;
   localparam int CLK_MHZ = 20;
   localparam int SETTLE_CYC = (SETTLE_US * CLK_MHZ < 1) ? 1 : SETTLE_US * CLK_MHZ;
   localparam int CNT_W = 12;
   // Register map
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h1;
   localparam logic [3:0] ADDR_INT_STAT = 4'h2;
   localparam logic [3:0] ADDR_INT_CLR = 4'h3;
   localparam logic [3:0] ADDR_INT_EN = 4'h4;
   localparam logic [31:0] RESET_CTRL = 32'h00000001;
   // Interrupt status bit positions
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_WARN = 1;
   localparam int IRQ_OPEN = 2;
   localparam int IRQ_W = 3;
   // Control bits
   localparam int CTRL_WARN_VARIANT = 0;
endpackage

// >>> verilog/settle_filter.sv
// State filter that passes a level only after it has held steady
`timescale 1ns/1ps
module settle_filter #(
   parameter int CYCLES = 200,
   parameter int CNT_W = 12
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Raw and filtered level
   input wire logic raw,
   output logic settled
);
   logic [CNT_W-1:0] cnt_r;

   // Restart the count on every change of the raw level
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         cnt_r <= '0;
      else if (raw == settled)
         cnt_r <= '0;
      else
         cnt_r <= cnt_r + 1'b1;
   end

   // Accept the new level only once it has held long enough
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         settled <= 1'b0;
      else if (raw != settled && cnt_r >= CNT_W'(CYCLES - 1))
         settled <= raw;
   end
endmodule

// >>> verilog/channel_gate.sv
// One channel output gate with over-temperature hold behaviour
`timescale 1ns/1ps
module channel_gate (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Conditions
   input wire logic request,
   input wire logic run_ok,
   input wire logic temp_fault,
   // Switch state
   output logic switch_on
);
   // Once on, a temperature fault lets it stay on; from off it blocks turn-on
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         switch_on <= 1'b0;
      else if (!request || !run_ok)
         switch_on <= 1'b0;
      else if (!temp_fault || switch_on)
         switch_on <= 1'b1;
   end
endmodule

// >>> verification/ssw_checker.sv
// Pin level assertions for the smart switch indicator logic
`timescale 1ns/1ps
module ssw_checker #(
   parameter int CHANNELS = 4
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Inputs of the block
   input wire logic logic_supply_above_uv,
   input wire logic switch_supply_above_low,
   input wire logic switch_supply_above_high,
   input wire logic [CHANNELS-1:0] over_current,
   input wire logic [CHANNELS-1:0] over_temp,
   input wire logic [CHANNELS-1:0] channel_control_input,
   input wire logic output_enable,
   // Watched outputs
   input wire logic [CHANNELS-1:0] switch_output,
   input wire logic [CHANNELS-1:0] channel_status_lamp_n_oe,
   input wire logic fault_indicator_n_out,
   input wire logic fault_indicator_n_oe,
   input wire logic open_load_indicator_n_out,
   input wire logic [CHANNELS-1:0] channel_status_lamp_n_out,
   input wire logic switch_supply_warning_n_out,
   input wire logic switch_supply_warning_n_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic [1:0] up_r;
   wire logic up = up_r[1];
   wire logic logic_supply = logic_supply_above_uv;
   wire logic bad = logic_supply && (!switch_supply_above_low || (|over_current));
   wire logic good = logic_supply && switch_supply_above_low && switch_supply_above_high
      && !(|over_current) && !(|over_temp);
   // Skip the edges right after reset, outputs are held low there
   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
         up_r <= 2'h0;
      else
         up_r <= {up_r[0], 1'b1};
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_bad;
      (up && bad)[*3];
   endsequence
   sequence s_on0;
      (up && good && channel_control_input[0] && output_enable)[*3];
   endsequence
   sequence s_off0;
      (up && !channel_control_input[0])[*3];
   endsequence
   a_fault_np:
      assert property (up && logic_supply && !switch_supply_above_low |=> fault_indicator_n_oe)
      else $error("fault pin idle on dead switch supply");
   a_fault_oc:
      assert property (up && logic_supply && (|over_current) |=> fault_indicator_n_oe)
      else $error("fault pin idle on over current");
   a_fault_clears:
      assert property (up && logic_supply && switch_supply_above_low && !(|over_current)
         |=> !fault_indicator_n_oe) else $error("fault pin stuck");
   a_fault_unpowered:
      assert property (up && !logic_supply |=> !fault_indicator_n_oe)
      else $error("fault pin driven without logic supply");
   a_no_high_drive:
      assert property (!fault_indicator_n_out && !open_load_indicator_n_out
         && !(|channel_status_lamp_n_out) && !switch_supply_warning_n_out)
      else $error("open drain pin driven high");
   a_warn_released:
      assert property (up && !logic_supply |=> !switch_supply_warning_n_oe)
      else $error("warning pin driven without logic supply");
   a_lamp_follows:
      assert property (channel_status_lamp_n_oe == switch_output)
      else $error("lamp differs from switch");
   a_off_in_fault:
      assert property (s_bad |-> ##2 !(|switch_output))
      else $error("switch on during fault");
   a_on_normal:
      assert property (s_on0 |-> ##2 switch_output[0])
      else $error("switch off with request and enable");
   a_off_request:
      assert property (s_off0 |-> ##2 !switch_output[0])
      else $error("switch on without request");
endmodule

// >>> verification/host_model.sv
// Host controller model driving channel requests and the enable
`timescale 1ns/1ps
module host_model #(
   parameter int CHANNELS = 4
) (
   // Clock
   input wire logic clk_sys,
   // Levels wanted by the bench
   input wire logic [CHANNELS-1:0] want_chan,
   input wire logic want_oe,
   // Pins into the device
   output logic [CHANNELS-1:0] channel_control_input,
   output logic output_enable
);
   // never floating
   // Pins start low and only take new levels just after an edge
   initial
   begin
      channel_control_input = {CHANNELS{1'b0}};
      output_enable = 1'b0;
   end
   always @(posedge clk_sys)
   begin
      channel_control_input <= want_chan;
      output_enable <= want_oe;
   end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the smart switch indicator logic
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] want_chan = 4'h0;
   logic want_oe = 1'b0;
   logic [3:0] channel_control_input;
   logic output_enable;
   logic logic_supply_above_uv = 1'b1;
   logic switch_supply_above_low = 1'b1;
   logic switch_supply_above_high = 1'b1;
   logic [3:0] over_current = 4'h0;
   logic [3:0] over_temp = 4'h0;
   logic [3:0] over_voltage = 4'h0;
   logic [3:0] load_present = 4'hf;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [3:0] switch_output;
   logic [3:0] channel_status_lamp_n_out;
   logic [3:0] channel_status_lamp_n_oe;
   logic fault_indicator_n_out;
   logic fault_indicator_n_oe;
   logic open_load_indicator_n_out;
   logic open_load_indicator_n_oe;
   logic switch_supply_warning_n_out;
   logic switch_supply_warning_n_oe;
   logic irq;
   int failures = 0;
   int total_checks = 0;
   // Short settle count keeps the indicator waits brief
   host_model #(.CHANNELS(4)) u_host_model (.*);
   smart_switch_indicator_logic #(.CHANNELS(4), .SETTLE_CYCLES(4))
      u_smart_switch_indicator_logic (.*);
   // 50 ns period
   initial
      forever #25 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Sample at the falling edge, after every register has landed
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask
   task automatic report_and_stop();
      if (failures == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] d;
      rreg(ssw_pkg::ADDR_CTRL, d);
      chk("ctrl", ssw_pkg::RESET_CTRL, d);
      wreg(ssw_pkg::ADDR_STAT, 32'hffffffff);
      rreg(ssw_pkg::ADDR_STAT, d);
      chk("stat", 32'h6, d);
      rreg(4'hf, d);
      chk("unmapped", 32'h0, d);
   endtask
   task automatic t_normal();
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk_sys);
         want_chan <= k[0] ? 4'hf : 4'h0;
         want_oe <= k[1];
         settle(6);
         chk("switch", (k == 3) ? 4'hf : 4'h0, switch_output);
         chk("lamp", (k == 3) ? 4'hf : 4'h0, channel_status_lamp_n_oe);
      end
   endtask
   task automatic t_temp();
      logic [31:0] d;
      @(posedge clk_sys);
      over_temp <= 4'h1;
      over_voltage <= 4'hf;
      settle(3);
      chk("hot on", 4'hf, switch_output);
      @(posedge clk_sys);
      want_chan <= 4'hd;
      settle(6);
      @(posedge clk_sys);
      over_temp <= 4'h3;
      want_chan <= 4'hf;
      settle(6);
      chk("hot off", 3'h6, switch_output[3:1]);
      rreg(ssw_pkg::ADDR_STAT, d);
      chk("stat hot", 32'hc6, d);
      @(posedge clk_sys);
      over_temp <= 4'h0;
      settle(6);
      chk("over volt", 4'hf, switch_output);
   endtask
   task automatic t_fault_irq();
      logic [31:0] d;
      wreg(ssw_pkg::ADDR_INT_EN, 32'h1);
      over_current <= 4'h2;
      settle(3);
      chk("fault", 1'b1, fault_indicator_n_oe);
      chk("switch", 4'h0, switch_output);
      chk("irq", 1'b1, irq);
      @(posedge clk_sys);
      over_current <= 4'h0;
      settle(4);
      chk("fault", 1'b0, fault_indicator_n_oe);
      chk("switch", 4'hf, switch_output);
      rreg(ssw_pkg::ADDR_INT_STAT, d);
      chk("int stat", 32'h1, d);
      wreg(ssw_pkg::ADDR_INT_CLR, 32'h1);
      wreg(ssw_pkg::ADDR_INT_EN, 32'h0);
      over_current <= 4'h8;
      settle(3);
      chk("irq masked", 1'b0, irq);
      @(posedge clk_sys);
      over_current <= 4'h0;
      rreg(ssw_pkg::ADDR_INT_STAT, d);
      chk("int stat", 32'h1, d);
      wreg(ssw_pkg::ADDR_INT_CLR, 32'h1);
   endtask
   task automatic t_supply();
      @(posedge clk_sys);
      switch_supply_above_low <= 1'b0;
      switch_supply_above_high <= 1'b0;
      settle(6);
      chk("np fault", 1'b1, fault_indicator_n_oe);
      chk("np switch", 4'h0, switch_output);
      @(posedge clk_sys);
      switch_supply_above_low <= 1'b1;
      switch_supply_above_high <= 1'b1;
      logic_supply_above_uv <= 1'b0;
      settle(6);
      chk("logic_supply fault", 1'b0, fault_indicator_n_oe);
      chk("logic_supply switch", 4'h0, switch_output);
      @(posedge clk_sys);
      logic_supply_above_uv <= 1'b1;
      settle(14);
   endtask
   task automatic t_warn();
      @(posedge clk_sys);
      switch_supply_above_high <= 1'b0;
      settle(1);
      @(posedge clk_sys);
      switch_supply_above_high <= 1'b1;
      settle(14);
      chk("warn glitch", 1'b0, switch_supply_warning_n_oe);
      @(posedge clk_sys);
      switch_supply_above_high <= 1'b0;
      settle(14);
      chk("warn", 1'b1, switch_supply_warning_n_oe);
      chk("warn switch", 4'hf, switch_output);
      @(posedge clk_sys);
      switch_supply_above_low <= 1'b0;
      settle(14);
      chk("warn held", 1'b1, switch_supply_warning_n_oe);
      @(posedge clk_sys);
      switch_supply_above_low <= 1'b1;
      switch_supply_above_high <= 1'b1;
      settle(14);
      chk("warn off", 1'b0, switch_supply_warning_n_oe);
   endtask
   task automatic t_open();
      wreg(ssw_pkg::ADDR_CTRL, 32'h0);
      load_present <= 4'hb;
      settle(1);
      @(posedge clk_sys);
      load_present <= 4'hf;
      settle(14);
      chk("open glitch", 1'b0, open_load_indicator_n_oe);
      @(posedge clk_sys);
      load_present <= 4'hb;
      settle(14);
      chk("open", 1'b1, open_load_indicator_n_oe);
      @(posedge clk_sys);
      load_present <= 4'hf;
      settle(14);
      chk("open off", 1'b0, open_load_indicator_n_oe);
   endtask
   // Main sequence after 20 cycles of reset
   initial
   begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs();
      t_normal();
      t_temp();
      t_fault_irq();
      t_supply();
      t_warn();
      t_open();
      report_and_stop();
   end
   // Watchdog against a hung sequence
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      report_and_stop();
   end
endmodule
bind smart_switch_indicator_logic ssw_checker #(.CHANNELS(CHANNELS)) u_ssw_checker (.*);
